/* rtl/cpudp_pkg.sv */
/*
 Package for the processor datapath: phase codes, arithmetic gate functions,
 address field positions, accumulator addresses and core memory geometry.
 Assumes nothing of its surroundings.
*/
package cpudp_pkg;
	localparam int WORD_W = 16;
	localparam int CORE_DATA_W = 17;
	localparam int STACK_WORDS = 8192;
	localparam int PAGE_WORDS = 1024;
	localparam int PAGES_PER_MODULE = 4;
	localparam int PAGES_PER_STACK = 8;
	localparam int ADDR_IND_BIT = 15;
	localparam int ADDR_STACK_HI = 14;
	localparam int ADDR_STACK_LO = 13;
	localparam int ADDR_PAGE_HI = 12;
	localparam int ADDR_PAGE_LO = 10;
	localparam int ADDR_LOC_HI = 9;
	localparam int INSN_OP_HI = 14;
	localparam int INSN_OP_LO = 11;
	localparam int INSN_ACC_SEL_BIT = 11;
	localparam int INSN_CUR_PAGE_BIT = 10;
	localparam int CARRY_BIT = 15;
	localparam int SHIFT_FOUR = 4;
	localparam logic [15:0] ACC_A_ADDR = 16'h0000;
	localparam logic [15:0] ACC_B_ADDR = 16'h0001;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef enum logic [1:0] {
		CPUDP_PH_FETCH,
		CPUDP_PH_INDIRECT,
		CPUDP_PH_EXECUTE,
		CPUDP_PH_DMA
	} cpudp_phase_type;

	typedef enum logic [3:0] {
		CPUDP_FN_ADD,
		CPUDP_FN_INC1,
		CPUDP_FN_INC2,
		CPUDP_FN_AND,
		CPUDP_FN_IOR,
		CPUDP_FN_XOR,
		CPUDP_FN_CMPL,
		CPUDP_FN_SHR1,
		CPUDP_FN_SHL1,
		CPUDP_FN_SHL4,
		CPUDP_FN_PASS_R,
		CPUDP_FN_PASS_S,
		CPUDP_FN_ROL_LINK,
		CPUDP_FN_ROR_LINK
	} cpudp_func_type;

	typedef enum logic [2:0] {
		CPUDP_RS_T,
		CPUDP_RS_P,
		CPUDP_RS_M,
		CPUDP_RS_ACC,
		CPUDP_RS_ZERO
	} cpudp_rsel_type;
endpackage

/* rtl/cpudp_core_mem.sv */
/*
 Core stack memory: 8192 words of 17 bits, data plus a spare parity bit.
 Assumes a synchronous write and a registered read on the same clock.
*/
`timescale 1ns/1ps
module cpudp_core_mem
	import cpudp_pkg::*;
#(
	parameter int DEPTH = STACK_WORDS,
	parameter int DATA_W = CORE_DATA_W
) (
	input wire logic ref_clk_i, // Machine clock
	input wire logic [$clog2(DEPTH)-1:0] addr_i, // Word location
	input wire logic wr_i, // Write strobe
	input wire logic [DATA_W-1:0] wdata_i, // Write data
	output logic [DATA_W-1:0] rdata_o // Registered read data
);
	logic [DATA_W-1:0] mem_ff [DEPTH];

	always_ff @(posedge ref_clk_i) begin
		if (wr_i) begin
			mem_ff[addr_i] <= wdata_i;
		end
		rdata_o <= mem_ff[addr_i];
	end
endmodule

/* rtl/cpudp_top.sv */
/*
 Processor datapath: phase sequencer, accumulators, link, overflow and skip
 flags, arithmetic gates, operand address formation and one core stack.
 Assumes the instruction decoder drives the control inputs for each machine
 cycle, and that stack select beyond stack zero maps onto the one stack built.
*/
// Overview of operation
// - Every DMA word transfer takes a DMA phase
// - One phase; indirect follows fetch or indirect
// - Execute follows fetch/indirect; instruction ends fetch/execute
// - Fetch, indirect, execute indicator outputs per phase
// - Two 16-bit accumulators hold data stably
// - Instruction bit 11 selects the accumulator
// - Addresses zero and one reach accumulators
// - Overflow loadable, set on positive overflow
// - Link catches bit 15 carry, rotates
// - Skip flag set skips next instruction
// - Gates add operand buses onto result
// - Gates increment first bus by one/two
// - Gates AND, OR, XOR both buses
// - Gates complement the first bus
// - Gates shift right one, left one, four
// - Gates pass either bus, 16 bits parallel
// - Result loads T, P, M, accumulators, flags
// - Stack of 8192 words, 17 bits each
// - Stack has two modules, four pages each
// - Address word: indirect, stack, page, location
// - Instruction: indirect, opcode, in-page address fields
// - Bit 10 direct selects current page
// - Current page comes from instruction address
// - Else page zero of first stack
// - Indirect chain until bit 15 clear
`timescale 1ns/1ps
module cpudp_top
	import cpudp_pkg::*;
#(
	parameter int W = WORD_W
) (
	input wire logic ref_clk_i, // Machine clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic cycle_i, // End of machine cycle, advance phase
	input wire logic dma_req_i, // DMA word transfer pending
	input wire logic dma_wr_i, // DMA transfer writes core
	input wire logic [W-1:0] dma_addr_i, // DMA core address
	input wire logic [W-1:0] dma_wdata_i, // DMA write data
	input wire logic multi_phase_i, // Current instruction needs execute
	input wire logic [2:0] r_sel_i, // First operand bus source
	input wire logic s_from_t_i, // Second bus from T, else switches
	input wire logic [W-1:0] switch_i, // Switch register value
	input wire logic [3:0] func_i, // Arithmetic gate function
	input wire logic ld_t_i, // Load T from result
	input wire logic ld_p_i, // Load P from result
	input wire logic ld_m_i, // Load M from result
	input wire logic ld_acc_i, // Load selected accumulator
	input wire logic ld_ovf_i, // Load overflow flag from result bit 0
	input wire logic ld_link_i, // Load link from result bit 0
	input wire logic ld_skip_i, // Load skip flag from result bit 0
	input wire logic mem_rd_i, // Read core at M into T
	input wire logic mem_wr_i, // Write T into core at M
	output logic [W-1:0] result_o, // Result bus
	output logic [W-1:0] t_o, // Transfer register
	output logic [W-1:0] p_o, // Program address register
	output logic [W-1:0] m_o, // Memory address register
	output logic [W-1:0] acc_a_o, // First accumulator
	output logic [W-1:0] acc_b_o, // Second accumulator
	output logic [W-1:0] operand_addr_o, // Formed operand address
	output logic [W-1:0] dma_rdata_o, // DMA read data
	output logic overflow_flag_o, // Overflow flag
	output logic link_bit_o, // Link bit
	output logic skip_flag_o, // Skip pending
	output logic fetch_o, // Fetch phase indicator
	output logic indirect_o, // Indirect phase indicator
	output logic execute_o, // Execute phase indicator
	output logic dma_phase_o // DMA phase indicator
);
	// Whole machine state, registered once per edge
	typedef struct packed {
		cpudp_phase_type phase;
		cpudp_phase_type resume;
		logic [W-1:0] t;
		logic [W-1:0] p;
		logic [W-1:0] m;
		logic [W-1:0] insn_addr;
		logic [5:0] ireg;
		logic [W-1:0] acc_a;
		logic [W-1:0] acc_b;
		logic ovf;
		logic link;
		logic skip;
		logic rd_pend;
		logic rd_acc;
		logic rd_dma;
		logic [W-1:0] rd_acc_val;
		logic [W-1:0] dma_rdata;
	} cpudp_state_type;

	cpudp_state_type cur_ff;
	cpudp_state_type nxt_cur;
	logic [W-1:0] r_bus;
	logic [W-1:0] s_bus;
	logic [W-1:0] res;
	logic [W:0] sum;
	logic carry;
	logic pos_ovf;
	logic acc_sel_b;
	logic [W-1:0] acc_sel;
	logic [W-1:0] core_addr;
	logic core_wr;
	logic [W-1:0] core_wdata;
	logic [CORE_DATA_W-1:0] core_rdata;
	logic [W-1:0] rd_word;
	logic acc_hit;
	logic insn_ind;
	logic insn_cur_page;
	logic [ADDR_LOC_HI:0] insn_loc;
	logic [ADDR_STACK_HI-ADDR_PAGE_LO:0] insn_page_src;
	logic [ADDR_PAGE_HI-ADDR_PAGE_LO:0] core_page;
	logic [ADDR_LOC_HI:0] core_loc;

	assign acc_sel_b = cur_ff.ireg[INSN_ACC_SEL_BIT - INSN_CUR_PAGE_BIT];
	assign acc_sel = acc_sel_b ? cur_ff.acc_b : cur_ff.acc_a;

	// Instruction word fields held in T, page source from the instruction address
	assign insn_ind = cur_ff.t[ADDR_IND_BIT];
	assign insn_cur_page = cur_ff.t[INSN_CUR_PAGE_BIT];
	assign insn_loc = cur_ff.t[ADDR_LOC_HI:0];
	assign insn_page_src = cur_ff.insn_addr[ADDR_STACK_HI:ADDR_PAGE_LO];

	always_comb begin
		case (cpudp_rsel_type'(r_sel_i))
			CPUDP_RS_T: r_bus = cur_ff.t;
			CPUDP_RS_P: r_bus = cur_ff.p;
			CPUDP_RS_M: r_bus = cur_ff.m;
			CPUDP_RS_ACC: r_bus = acc_sel;
			default: r_bus = WORD_RESET;
		endcase
		s_bus = s_from_t_i ? cur_ff.t : switch_i;
	end

	// Arithmetic gates, all 16 bits in parallel
	always_comb begin
		sum = {1'b0, r_bus} + {1'b0, s_bus};
		carry = 1'b0;
		pos_ovf = 1'b0;
		case (cpudp_func_type'(func_i))
			CPUDP_FN_ADD: begin
				sum = {1'b0, r_bus} + {1'b0, s_bus};
				carry = sum[W];
				pos_ovf = ~r_bus[W-1] & ~s_bus[W-1] & sum[W-1];
			end
			CPUDP_FN_INC1: begin
				sum = {1'b0, r_bus} + 17'h00001;
				carry = sum[W];
				pos_ovf = ~r_bus[W-1] & sum[W-1];
			end
			CPUDP_FN_INC2: begin
				sum = {1'b0, r_bus} + 17'h00002;
				carry = sum[W];
				pos_ovf = ~r_bus[W-1] & sum[W-1];
			end
			default: begin
				sum = {1'b0, r_bus};
			end
		endcase
		case (cpudp_func_type'(func_i))
			CPUDP_FN_ADD, CPUDP_FN_INC1, CPUDP_FN_INC2: res = sum[W-1:0];
			CPUDP_FN_AND: res = r_bus & s_bus;
			CPUDP_FN_IOR: res = r_bus | s_bus;
			CPUDP_FN_XOR: res = r_bus ^ s_bus;
			CPUDP_FN_CMPL: res = ~r_bus;
			CPUDP_FN_SHR1: res = r_bus >> 1;
			CPUDP_FN_SHL1: res = r_bus << 1;
			CPUDP_FN_SHL4: res = r_bus << SHIFT_FOUR;
			CPUDP_FN_PASS_R: res = r_bus;
			CPUDP_FN_PASS_S: res = s_bus;
			CPUDP_FN_ROL_LINK: res = {r_bus[W-2:0], cur_ff.link};
			CPUDP_FN_ROR_LINK: res = {cur_ff.link, r_bus[W-1:1]};
			default: res = r_bus;
		endcase
	end

	// Operand address from the instruction word held in T
	always_comb begin
		if (insn_cur_page) begin
			operand_addr_o = {1'b0, insn_page_src, insn_loc};
		end else begin
			operand_addr_o = {6'h00, insn_loc};
		end
	end

	// Accumulators answer at addresses zero and one
	assign acc_hit = (cur_ff.m == ACC_A_ADDR) || (cur_ff.m == ACC_B_ADDR);
	always_comb begin
		if (dma_phase_o) begin
			core_addr = dma_addr_i;
			core_wr = dma_wr_i;
			core_wdata = dma_wdata_i;
		end else begin
			core_addr = cur_ff.m;
			core_wr = mem_wr_i && !acc_hit;
			core_wdata = cur_ff.t;
		end
	end

	// Stack bits dropped: only one stack is built
	assign core_page = core_addr[ADDR_PAGE_HI:ADDR_PAGE_LO];
	assign core_loc = core_addr[ADDR_LOC_HI:0];
	cpudp_core_mem #(
		.DEPTH(STACK_WORDS),
		.DATA_W(CORE_DATA_W)
	) u_core (
		.ref_clk_i(ref_clk_i),
		.addr_i({core_page, core_loc}),
		.wr_i(core_wr),
		.wdata_i({1'b0, core_wdata}),
		.rdata_o(core_rdata)
	);

	assign rd_word = cur_ff.rd_acc ? cur_ff.rd_acc_val : core_rdata[W-1:0];

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.rd_pend = 1'b0;
		nxt_cur.rd_dma = 1'b0;
		if (cur_ff.rd_pend) begin
			nxt_cur.t = rd_word;
		end
		if (cur_ff.rd_dma) begin
			nxt_cur.dma_rdata = core_rdata[W-1:0];
		end
		if (!dma_phase_o) begin
			if (mem_rd_i) begin
				nxt_cur.rd_pend = 1'b1;
				nxt_cur.rd_acc = acc_hit;
				nxt_cur.rd_acc_val = (cur_ff.m == ACC_B_ADDR) ? cur_ff.acc_b : cur_ff.acc_a;
			end
			if (mem_wr_i && acc_hit) begin
				if (cur_ff.m == ACC_B_ADDR) begin
					nxt_cur.acc_b = cur_ff.t;
				end else begin
					nxt_cur.acc_a = cur_ff.t;
				end
			end
			if (ld_t_i) begin
				nxt_cur.t = res;
			end
			if (ld_p_i) begin
				nxt_cur.p = res;
			end
			if (ld_m_i) begin
				nxt_cur.m = res;
			end
			if (ld_acc_i) begin
				if (acc_sel_b) begin
					nxt_cur.acc_b = res;
				end else begin
					nxt_cur.acc_a = res;
				end
			end
			// Hardware set wins over a load in the same cycle
			if (ld_acc_i && pos_ovf) begin
				nxt_cur.ovf = 1'b1;
			end else if (ld_ovf_i) begin
				nxt_cur.ovf = res[0];
			end
			if (ld_acc_i && carry) begin
				nxt_cur.link = 1'b1;
			end else if (ld_link_i) begin
				nxt_cur.link = res[0];
			end else if (ld_acc_i && func_i == 4'(CPUDP_FN_ROL_LINK)) begin
				nxt_cur.link = r_bus[W-1];
			end else if (ld_acc_i && func_i == 4'(CPUDP_FN_ROR_LINK)) begin
				nxt_cur.link = r_bus[0];
			end
		end
		// Phase sequencer advances only on cycle_i
		if (cycle_i) begin
			case (cur_ff.phase)
				CPUDP_PH_FETCH: begin
					nxt_cur.ireg = cur_ff.t[W-1:INSN_CUR_PAGE_BIT];
					nxt_cur.insn_addr = cur_ff.m;
					if (cur_ff.skip) begin
						nxt_cur.p = cur_ff.p + 16'h0001;
						nxt_cur.skip = 1'b0;
						nxt_cur.phase = CPUDP_PH_FETCH;
					end else if (multi_phase_i && insn_ind) begin
						nxt_cur.phase = CPUDP_PH_INDIRECT;
					end else if (multi_phase_i) begin
						nxt_cur.phase = CPUDP_PH_EXECUTE;
					end else begin
						nxt_cur.phase = CPUDP_PH_FETCH;
					end
				end
				CPUDP_PH_INDIRECT: begin
					if (cur_ff.t[ADDR_IND_BIT]) begin
						nxt_cur.phase = CPUDP_PH_INDIRECT;
					end else begin
						nxt_cur.phase = CPUDP_PH_EXECUTE;
					end
				end
				CPUDP_PH_EXECUTE: nxt_cur.phase = CPUDP_PH_FETCH;
				CPUDP_PH_DMA: nxt_cur.phase = cur_ff.resume;
				default: nxt_cur.phase = CPUDP_PH_FETCH;
			endcase
			// DMA steals one machine cycle, then resumes
			if (dma_req_i && cur_ff.phase != CPUDP_PH_DMA) begin
				nxt_cur.resume = nxt_cur.phase;
				nxt_cur.phase = CPUDP_PH_DMA;
				nxt_cur.rd_dma = 1'b0;
			end
		end
		if (ld_skip_i && !dma_phase_o) begin
			nxt_cur.skip = res[0];
		end
		if (dma_phase_o && !dma_wr_i) begin
			nxt_cur.rd_dma = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Registered state and the combinational result bus straight to the pins
	assign result_o = res;
	assign t_o = cur_ff.t;
	assign p_o = cur_ff.p;
	assign m_o = cur_ff.m;
	assign acc_a_o = cur_ff.acc_a;
	assign acc_b_o = cur_ff.acc_b;
	assign dma_rdata_o = cur_ff.dma_rdata;
	assign overflow_flag_o = cur_ff.ovf;
	assign link_bit_o = cur_ff.link;
	assign skip_flag_o = cur_ff.skip;
	assign fetch_o = cur_ff.phase == CPUDP_PH_FETCH;
	assign indirect_o = cur_ff.phase == CPUDP_PH_INDIRECT;
	assign execute_o = cur_ff.phase == CPUDP_PH_EXECUTE;
	assign dma_phase_o = cur_ff.phase == CPUDP_PH_DMA;
endmodule

/* dv/cpudp_monitor.sv */
/*
 Checker for the datapath ports: phase order, accumulator hold, gate results and T loads.
 Assumes it is bound to cpudp_top, with one clock and an active-high reset.
*/
`timescale 1ns/1ps
module cpudp_monitor
	import cpudp_pkg::*;
#(
	parameter int W = WORD_W
) (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic cycle_i, // Phase advance
	input wire logic dma_req_i, // DMA pending
	input wire logic [2:0] r_sel_i, // R source
	input wire logic s_from_t_i, // S source
	input wire logic [W-1:0] switch_i, // Switches
	input wire logic [3:0] func_i, // Gate function
	input wire logic ld_t_i, // Load T
	input wire logic ld_acc_i, // Load acc
	input wire logic mem_wr_i, // Core write
	input wire logic [W-1:0] result_o, // Result
	input wire logic [W-1:0] t_o, // T
	input wire logic [W-1:0] acc_a_o, // Acc A
	input wire logic [W-1:0] acc_b_o, // Acc B
	input wire logic fetch_o, // Fetch
	input wire logic indirect_o, // Indirect
	input wire logic execute_o, // Execute
	input wire logic dma_phase_o // DMA
);
	default clocking mon_cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	a_one_phase: assert property (
		$onehot({fetch_o, indirect_o, execute_o, dma_phase_o})) else $error("phase not one-hot");
	a_ind_order: assert property (
		$rose(indirect_o) && !$past(dma_phase_o) |-> $past(fetch_o)) else $error("indirect not after fetch");
	a_phase_hold: assert property (
		!cycle_i |=> $stable({fetch_o, indirect_o, execute_o, dma_phase_o})) else $error("phase moved");
	a_dma_entry: assert property (
		cycle_i && dma_req_i && !dma_phase_o |=> dma_phase_o) else $error("no DMA phase");
	a_acc_hold: assert property (
		!ld_acc_i && !mem_wr_i && !$past(mem_wr_i) && !dma_phase_o |=> $stable(acc_a_o) && $stable(acc_b_o))
		else $error("accumulator changed");
	a_add_gate: assert property (
		func_i == 4'h0 && r_sel_i == 3'h0 && !s_from_t_i |-> result_o == t_o + switch_i) else $error("bad sum");
	a_inc_gate: assert property (
		func_i == 4'h1 && r_sel_i == 3'h0 |-> result_o == t_o + 16'h0001) else $error("bad increment");
	a_cmpl_gate: assert property (
		func_i == 4'h6 && r_sel_i == 3'h0 |-> result_o == ~t_o) else $error("bad complement");
	a_and_gate: assert property (
		func_i == 4'h3 && r_sel_i == 3'h0 && !s_from_t_i |-> result_o == (t_o & switch_i)) else $error("bad and");
	a_shl4_gate: assert property (
		func_i == 4'h9 && r_sel_i == 3'h0 |-> result_o == {t_o[W-5:0], 4'h0}) else $error("bad shift by four");
	a_t_load: assert property (
		ld_t_i && !dma_phase_o |=> t_o == $past(result_o)) else $error("T not loaded");
endmodule

bind cpudp_top cpudp_monitor #(.W(W)) u_mon (.ref_clk_i, .rst_i, .cycle_i, .dma_req_i, .r_sel_i, .s_from_t_i,
	.switch_i, .func_i, .ld_t_i, .ld_acc_i, .mem_wr_i, .result_o, .t_o, .acc_a_o, .acc_b_o, .fetch_o,
	.indirect_o, .execute_o, .dma_phase_o);

/* dv/cpudp_decoder_model.sv */
/*
 Decoder-side model: gives end-of-machine-cycle pulses to the phase sequencer.
 Assumes the bench asks for a pulse one falling edge ahead.
*/
`timescale 1ns/1ps
module cpudp_decoder_model (
	input wire logic ref_clk_i, // Machine clock
	input wire logic adv_i, // Pulse request
	output logic cycle_o // End of cycle
);
	initial cycle_o = 1'b0;
	always @(negedge ref_clk_i) begin
		cycle_o <= adv_i;
	end
endmodule

/* dv/cpudp_top_bench.sv */
/*
 Self-checking bench for the datapath: gate table, loads, flags, accumulator addressing, phases.
 Assumes cpudp_top, the decoder model and a 4 ns clock.
*/
`timescale 1ns/1ps
module cpudp_top_bench;
	import cpudp_pkg::*;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, cycle_i, adv = 1'b0;
	logic dma_req_i = 1'b0, dma_wr_i = 1'b0, multi_phase_i = 1'b0, s_from_t_i = 1'b0;
	logic mem_rd_i = 1'b0, mem_wr_i = 1'b0, ld_t_i = 1'b0, ld_p_i = 1'b0, ld_m_i = 1'b0;
	logic ld_acc_i = 1'b0, ld_ovf_i = 1'b0, ld_link_i = 1'b0, ld_skip_i = 1'b0;
	logic [15:0] dma_addr_i = 16'h0000, dma_wdata_i = 16'h0000, switch_i = 16'h0000;
	logic [2:0] r_sel_i = 3'h0;
	logic [3:0] func_i = 4'h0;
	logic [15:0] result_o, t_o, p_o, m_o, acc_a_o, acc_b_o, operand_addr_o, dma_rdata_o;
	logic overflow_flag_o, link_bit_o, skip_flag_o, fetch_o, indirect_o, execute_o, dma_phase_o;
	int num_errors = 0, checks = 0;
	// Function code beside expected result for T=1234, switches=8421
	logic [19:0] tbl [15] = '{20'h09655, 20'h11235, 20'h21236, 20'h30020, 20'h49635, 20'h59615,
		20'h6EDCB, 20'h7091A, 20'h82468, 20'h92340, 20'hA1234, 20'hB8421, 20'hC2468, 20'hD091A,
		20'hE1234};

	cpudp_top uut (.ref_clk_i, .rst_i, .cycle_i, .dma_req_i, .dma_wr_i, .dma_addr_i, .dma_wdata_i,
		.multi_phase_i, .r_sel_i, .s_from_t_i, .switch_i, .func_i, .ld_t_i, .ld_p_i, .ld_m_i, .ld_acc_i,
		.ld_ovf_i, .ld_link_i, .ld_skip_i, .mem_rd_i, .mem_wr_i, .result_o, .t_o, .p_o, .m_o, .acc_a_o,
		.acc_b_o, .operand_addr_o, .dma_rdata_o, .overflow_flag_o, .link_bit_o, .skip_flag_o, .fetch_o,
		.indirect_o, .execute_o, .dma_phase_o);
	cpudp_decoder_model u_dec (.ref_clk_i(ref_clk_i), .adv_i(adv), .cycle_o(cycle_i));

	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] ph();
		return {12'h000, fetch_o, indirect_o, execute_o, dma_phase_o};
	endfunction

	// One gate setting, with loads {T,P,M,acc,ovf,link,skip} for one edge
	task automatic op(input logic [2:0] r, input logic [3:0] f, input logic [15:0] s, input logic [6:0] l);
		@(negedge ref_clk_i);
		r_sel_i <= r;
		func_i <= f;
		switch_i <= s;
		{ld_t_i, ld_p_i, ld_m_i, ld_acc_i, ld_ovf_i, ld_link_i, ld_skip_i} <= l;
		@(negedge ref_clk_i);
		{ld_t_i, ld_p_i, ld_m_i, ld_acc_i, ld_ovf_i, ld_link_i, ld_skip_i} <= 7'h00;
	endtask

	task automatic cyc();
		@(negedge ref_clk_i);
		adv <= 1'b1;
		@(negedge ref_clk_i);
		adv <= 1'b0;
		@(negedge ref_clk_i);
	endtask

	task automatic mem(input logic r, input logic w);
		@(negedge ref_clk_i);
		mem_rd_i <= r;
		mem_wr_i <= w;
		@(negedge ref_clk_i);
		mem_rd_i <= 1'b0;
		mem_wr_i <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		end_sim();
	end

	initial begin
		repeat (10) @(negedge ref_clk_i);
		rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(ph(), 16'h0008);
		op(3'h4, 4'hB, 16'h1234, 7'h40);
		for (int i = 0; i < 15; i++) begin
			op(3'h0, tbl[i][19:16], 16'h8421, 7'h00);
			chk(result_o, tbl[i][15:0]);
		end
		op(3'h4, 4'hB, 16'h0800, 7'h40);
		cyc();
		op(3'h4, 4'hB, 16'h5A5A, 7'h08);
		chk(acc_b_o, 16'h5A5A);
		chk(acc_a_o, 16'h0000);
		op(3'h4, 4'hB, 16'h0000, 7'h40);
		cyc();
		op(3'h4, 4'hB, 16'h7FFF, 7'h40);
		op(3'h0, 4'h0, 16'h0001, 7'h08);
		chk(acc_a_o, 16'h8000);
		chk({15'h0000, overflow_flag_o}, 16'h0001);
		op(3'h4, 4'hB, 16'hFFFF, 7'h40);
		op(3'h0, 4'h0, 16'h0001, 7'h08);
		chk({15'h0000, link_bit_o}, 16'h0001);
		op(3'h4, 4'hA, 16'h0000, 7'h04);
		chk({15'h0000, overflow_flag_o}, 16'h0000);
		op(3'h4, 4'hB, 16'h0001, 7'h01);
		cyc();
		chk(p_o, 16'h0001);
		chk({15'h0000, skip_flag_o}, 16'h0000);
		op(3'h4, 4'hA, 16'h0000, 7'h10);
		op(3'h4, 4'hB, 16'hABCD, 7'h40);
		mem(1'b0, 1'b1);
		chk(acc_a_o, 16'hABCD);
		op(3'h4, 4'hB, 16'h0001, 7'h10);
		mem(1'b1, 1'b0);
		chk(t_o, 16'h5A5A);
		op(3'h4, 4'hB, 16'h8000, 7'h40);
		multi_phase_i <= 1'b1;
		cyc();
		chk(ph(), 16'h0004);
		cyc();
		chk(ph(), 16'h0004);
		op(3'h4, 4'hB, 16'h0000, 7'h40);
		cyc();
		chk(ph(), 16'h0002);
		multi_phase_i <= 1'b0;
		cyc();
		chk(ph(), 16'h0008);
		dma_req_i <= 1'b1;
		cyc();
		chk(ph(), 16'h0001);
		dma_req_i <= 1'b0;
		op(3'h4, 4'hB, 16'hFFFF, 7'h40);
		chk(t_o, 16'h0000);
		cyc();
		chk(ph(), 16'h0008);
		dma_addr_i <= 16'h0123;
		dma_wdata_i <= 16'hBEEF;
		dma_wr_i <= 1'b1;
		dma_req_i <= 1'b1;
		cyc();
		dma_req_i <= 1'b0;
		cyc();
		chk(ph(), 16'h0008);
		dma_wr_i <= 1'b0;
		dma_req_i <= 1'b1;
		cyc();
		dma_req_i <= 1'b0;
		cyc();
		chk(dma_rdata_o, 16'hBEEF);
		op(3'h4, 4'hB, 16'h0123, 7'h10);
		chk(m_o, 16'h0123);
		mem(1'b1, 1'b0);
		chk(t_o, 16'hBEEF);
		op(3'h4, 4'hB, 16'h1C05, 7'h10);
		op(3'h4, 4'hB, 16'h0412, 7'h40);
		cyc();
		chk(operand_addr_o, 16'h1C12);
		op(3'h4, 4'hB, 16'h8412, 7'h40);
		chk(operand_addr_o, 16'h1C12);
		op(3'h4, 4'hB, 16'h0012, 7'h40);
		chk(operand_addr_o, 16'h0012);
		multi_phase_i <= 1'b1;
		cyc();
		chk(ph(), 16'h0002);
		multi_phase_i <= 1'b0;
		rst_i <= 1'b1;
		@(negedge ref_clk_i);
		chk(ph(), 16'h0008);
		rst_i <= 1'b0;
		cyc();
		chk(ph(), 16'h0008);
		end_sim();
	end
endmodule
